// [logic/cfg_id_pkg.sv]
// Package of constants for the configuration identity and port relocation bank
// Functional notes
// - Registers answer only in configuration state, indexed
// - Identity register read only, fixed code
// - Revision register read only, returns revision
// - Three test registers read/write, reset zero
// - Low holds base bits 7-0, high 10-8
// - Decoder matches A15-11 zero, A10-1 base
// - Base even; low bit 0 reads zero
// - High register bits 7-3 read zero
// - Reset loads strap default low, high zero
// - High write moves the decoder base
// - Register after pair reserved, reads zero
package cfg_id_pkg;
  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [7:0] IDX_DEVICE_IDENTITY = 8'h0d;
  localparam logic [7:0] IDX_SILICON_REVISION = 8'h0e;
  localparam logic [7:0] IDX_TEST_CONTROL_A = 8'h0f;
  localparam logic [7:0] IDX_TEST_CONTROL_B = 8'h10;
  localparam logic [7:0] IDX_TEST_CONTROL_C = 8'h11;
  localparam logic [7:0] IDX_PORT_BASE_LOW = 8'h12;
  localparam logic [7:0] IDX_PORT_BASE_HIGH = 8'h13;
  localparam logic [7:0] IDX_RESERVED_AFTER_BASE = 8'h14;
  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] BASE_LOW_STRAP0 = 8'h2e;
  localparam logic [7:0] BASE_LOW_STRAP1 = 8'h4e;
  localparam logic [7:0] BASE_HIGH_RESET = 8'h00;
  localparam logic [7:0] BASE_LOW_MASK = 8'hfe;
  localparam logic [7:0] BASE_HIGH_MASK = 8'h07;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // Identity and revision; values are arbitrary
  localparam logic [7:0] DEVICE_IDENTITY_CODE = 8'ha5;
  localparam logic [7:0] SILICON_REVISION_CODE = 8'h01;
  // ****************************************
  // Address layout
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int BASE_W = 11;
  localparam logic [4:0] ADDR_HIGH_ZERO = 5'h00;
  // Test register bank depth
  localparam int TEST_DEPTH = 3;
endpackage

// [logic/test_reg_mem.sv]
// Small register memory holding the three test-control registers
`timescale 1ns/1ps
`default_nettype none
module test_reg_mem (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_sel,
  output logic [7:0] rd_data
);
  import cfg_id_pkg::*;
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [TEST_DEPTH-1:0][7:0] mem; // Test registers
    logic [7:0] rd;                  // Registered read data
  } mem_state_t;
  mem_state_t s_q;
  mem_state_t s_d;
  // Next state: write and read select
  always_comb begin
    s_d = s_q;
    if (wr_en && (wr_sel < 2'(TEST_DEPTH))) begin
      s_d.mem[wr_sel] = wr_data;
    end
    if (rd_sel < 2'(TEST_DEPTH)) begin
      s_d.rd = s_d.mem[rd_sel];
    end else begin
      s_d.rd = READ_ZERO;
    end
  end
  // Registers, cleared at reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rd_data = s_q.rd;
endmodule
`default_nettype wire

// [logic/cfg_id_bank.sv]
// Identity, revision, test and configuration-port relocation registers
`timescale 1ns/1ps
`default_nettype none
module cfg_id_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hard_reset,
  input wire logic base_address_strap_pin,
  input wire logic config_state,
  input wire logic [7:0] config_index_register,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [cfg_id_pkg::ADDR_W-1:0] io_addr,
  input wire logic io_valid,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic port_hit,
  output logic [cfg_id_pkg::BASE_W-1:0] port_base
);
  import cfg_id_pkg::*;
  // ****************************************
  // Helpers
  // ****************************************
  // Index match, only inside configuration state
  function automatic logic sel(input logic [7:0] idx);
    sel = config_state && (config_index_register == idx);
  endfunction
  // Strap default for the low base register
  function automatic logic [7:0] low_default(input logic strap);
    low_default = strap ? BASE_LOW_STRAP1 : BASE_LOW_STRAP0;
  endfunction
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    ST_BOOT = 2'b01, // Waiting to catch the strap
    ST_RUN = 2'b10   // Normal operation
  } phase_t;
  typedef struct packed {
    phase_t phase;           // Boot or run
    logic [7:0] base_low;    // Held low base byte
    logic [7:0] base_high;   // High base bits
    logic [BASE_W-1:0] base; // Active decoder base
    logic [7:0] rdata;       // Read data
    logic rvalid;            // Read valid pulse
    logic hit;               // Decoder match
  } bank_state_t;
  bank_state_t s_q;
  bank_state_t s_d;
  logic test_wr;
  logic [1:0] test_sel;
  logic [7:0] test_rdata;
  logic test_rd_q;
  // Test register selection
  always_comb begin
    test_sel = 2'd3;
    if (sel(IDX_TEST_CONTROL_A)) begin
      test_sel = 2'd0;
    end else if (sel(IDX_TEST_CONTROL_B)) begin
      test_sel = 2'd1;
    end else if (sel(IDX_TEST_CONTROL_C)) begin
      test_sel = 2'd2;
    end
    test_wr = reg_wr && (test_sel != 2'd3);
  end
  // Test-control register storage
  test_reg_mem u_test (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(test_wr),
    .wr_sel(test_sel),
    .wr_data(reg_wdata),
    .rd_sel(test_sel),
    .rd_data(test_rdata)
  );
  // Remember whether the read targets the test bank
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      test_rd_q <= 1'b0;
    end else begin
      test_rd_q <= reg_rd && (test_sel != 2'd3);
    end
  end
  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    case (s_q.phase)
      ST_BOOT: begin
        // Strap caught after reset release
        s_d.base_low = low_default(base_address_strap_pin);
        s_d.base_high = BASE_HIGH_RESET;
        s_d.base = {s_d.base_high[2:0], s_d.base_low};
        s_d.phase = ST_RUN;
      end
      ST_RUN: begin
        if (hard_reset) begin
          // Hard reset reloads the pair
          s_d.base_low = low_default(base_address_strap_pin);
          s_d.base_high = BASE_HIGH_RESET;
          s_d.base = {s_d.base_high[2:0], s_d.base_low};
        end else if (reg_wr) begin
          if (sel(IDX_PORT_BASE_LOW)) begin
            // Held only; decoder unchanged
            s_d.base_low = reg_wdata & BASE_LOW_MASK;
          end else if (sel(IDX_PORT_BASE_HIGH)) begin
            s_d.base_high = reg_wdata & BASE_HIGH_MASK;
            s_d.base = {s_d.base_high[2:0], s_q.base_low};
          end
          // Identity, revision, reserved writes ignored
        end
        if (reg_rd) begin
          s_d.rvalid = 1'b1;
          if (sel(IDX_DEVICE_IDENTITY)) begin
            s_d.rdata = DEVICE_IDENTITY_CODE;
          end else if (sel(IDX_SILICON_REVISION)) begin
            s_d.rdata = SILICON_REVISION_CODE;
          end else if (sel(IDX_PORT_BASE_LOW)) begin
            s_d.rdata = s_q.base_low & BASE_LOW_MASK;
          end else if (sel(IDX_PORT_BASE_HIGH)) begin
            s_d.rdata = s_q.base_high & BASE_HIGH_MASK;
          end else begin
            // Reserved, unselected and test reads
            s_d.rdata = READ_ZERO;
          end
        end
      end
      default: begin
        s_d.phase = ST_BOOT;
      end
    endcase
    // Decoder on the active base, address bit 0 ignored
    s_d.hit = io_valid && (io_addr[15:11] == ADDR_HIGH_ZERO)
              && (io_addr[10:1] == s_q.base[10:1]);
  end
  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q.phase <= ST_BOOT;
      s_q.base_low <= BASE_LOW_STRAP0;
      s_q.base_high <= BASE_HIGH_RESET;
      s_q.base <= {BASE_HIGH_RESET[2:0], BASE_LOW_STRAP0};
      s_q.rdata <= READ_ZERO;
      s_q.rvalid <= 1'b0;
      s_q.hit <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end
  // Output register; test data comes from its own register in the same cycle as bank data
  logic [7:0] rdata_q;
  logic rvalid_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= test_rd_q ? test_rdata : s_q.rdata;
      rvalid_q <= s_q.rvalid;
    end
  end
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign port_hit = s_q.hit;
  assign port_base = s_q.base;
endmodule
`default_nettype wire

// [tb/cfg_id_bank_checker.sv]
// Port checks for the identity and base bank
`timescale 1ns/1ps
`default_nettype none
module cfg_id_bank_checker
  import cfg_id_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hard_reset,
  input wire logic base_address_strap_pin,
  input wire logic config_state,
  input wire logic [7:0] config_index_register,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [cfg_id_pkg::ADDR_W-1:0] io_addr,
  input wire logic io_valid,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic port_hit,
  input wire logic [cfg_id_pkg::BASE_W-1:0] port_base
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Accepted write, not overridden by hard reset
  wire logic wr_ok = reg_wr && config_state && !hard_reset;
  // Decoder match on the current base
  wire logic io_match = io_valid && io_addr[15:11] == 5'h00 && io_addr[10:1] == port_base[10:1];
  // Read of one index up to its answer
  sequence s_rd(i);
    reg_rd && config_state && config_index_register == i ##2 reg_rvalid;
  endsequence
  a_read_answer: assert property (reg_rd |-> ##2 reg_rvalid) else $error("late answer");
  a_id_fixed: assert property (s_rd(IDX_DEVICE_IDENTITY) |->
    reg_rdata == DEVICE_IDENTITY_CODE) else $error("identity changed");
  a_low_even: assert property (s_rd(IDX_PORT_BASE_LOW) |->
    !reg_rdata[0] && !port_base[0]) else $error("base odd");
  a_high_zero: assert property (s_rd(IDX_PORT_BASE_HIGH) |->
    reg_rdata[7:3] == 5'h00) else $error("high bits set");
  a_low_held: assert property (wr_ok && config_index_register == IDX_PORT_BASE_LOW
    |=> $stable(port_base)) else $error("base moved early");
  a_base_moves: assert property (wr_ok && config_index_register == IDX_PORT_BASE_HIGH
    |=> port_base[10:8] == $past(reg_wdata[2:0])) else $error("base not moved");
  a_hard_reload: assert property (hard_reset |=>
    port_base == ($past(base_address_strap_pin) ? 11'h04e : 11'h02e)) else $error("no reload");
  a_hit_decode: assert property (port_hit == $past(io_match)) else $error("bad decode");
endmodule
bind cfg_id_bank cfg_id_bank_checker u_chk (.clk_sys, .rst_n, .hard_reset,
  .base_address_strap_pin, .config_state, .config_index_register, .reg_wr, .reg_rd,
  .reg_wdata, .io_addr, .io_valid, .reg_rdata, .reg_rvalid, .port_hit, .port_base);
`default_nettype wire

// [tb/host_model.sv]
// Host model driving index/data strobes and I/O cycles
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  input wire logic port_hit,
  output logic config_state,
  output logic [7:0] config_index_register,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  output logic [15:0] io_addr,
  output logic io_valid
);
  initial {config_state, config_index_register, reg_wr, reg_rd} = '0;
  initial {reg_wdata, io_addr, io_valid} = '0;
  // One access; index loaded with the strobe, answer taken while it stands
  task automatic acc(input logic w, input logic c, input logic [7:0] i,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    config_state = c;
    config_index_register = i;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d;
    // Read data stands for one cycle after the second edge on
    @(negedge clk_sys);
    q = reg_rdata;
  endtask
  // One I/O cycle; address inverted once released
  task automatic io(input logic [15:0] a, output logic h);
    @(negedge clk_sys);
    io_addr = a;
    io_valid = 1'b1;
    @(negedge clk_sys);
    h = port_hit;
    io_valid = 1'b0;
    io_addr = ~a;
  endtask
endmodule
`default_nettype wire

// [tb/config_id_and_port_relocation_tb.sv]
// Self-checking bench for the identity and base bank
`timescale 1ns/1ps
`default_nettype none
module config_id_and_port_relocation_tb;
  import cfg_id_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hard_reset = 1'b0;
  logic base_address_strap_pin = 1'b0;
  logic config_state, reg_wr, reg_rd, io_valid, reg_rvalid, port_hit;
  logic [7:0] config_index_register, reg_wdata, reg_rdata, junk;
  logic [15:0] io_addr;
  logic [10:0] port_base;
  int miscompares = 0;
  int comparisons = 0;
  logic [7:0] rst_tab [8] = '{DEVICE_IDENTITY_CODE, SILICON_REVISION_CODE, 8'h00, 8'h00,
    8'h00, 8'h2e, 8'h00, 8'h00};
  always #20 clk_sys = ~clk_sys;
  cfg_id_bank u_dut (.clk_sys, .rst_n, .hard_reset, .base_address_strap_pin, .config_state,
    .config_index_register, .reg_wr, .reg_rd, .reg_wdata, .io_addr, .io_valid, .reg_rdata,
    .reg_rvalid, .port_hit, .port_base);
  host_model u_host (.clk_sys, .reg_rdata, .port_hit, .config_state, .config_index_register,
    .reg_wr, .reg_rd, .reg_wdata, .io_addr, .io_valid);
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic c, input logic [7:0] i, input logic [7:0] e);
    logic [7:0] q;
    u_host.acc(1'b0, c, i, 8'h00, q);
    chk("reg", e, q);
  endtask
  task automatic probe(input logic [15:0] a, input logic e);
    logic h;
    u_host.io(a, h);
    chk("hit", e, h);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    for (int k = 0; k < 8; k++)
      rdchk(1'b1, IDX_DEVICE_IDENTITY + 8'(k), rst_tab[k]);
    chk("base", 11'h02e, port_base);
    probe(16'h002f, 1'b1);
    probe(16'h082e, 1'b0);
    probe(16'h0030, 1'b0);
    u_host.acc(1'b1, 1'b1, IDX_DEVICE_IDENTITY, 8'h00, junk);
    rdchk(1'b1, IDX_DEVICE_IDENTITY, DEVICE_IDENTITY_CODE);
    u_host.acc(1'b1, 1'b1, IDX_SILICON_REVISION, 8'hff, junk);
    rdchk(1'b1, IDX_SILICON_REVISION, SILICON_REVISION_CODE);
    for (int k = 0; k < 3; k++)
      u_host.acc(1'b1, 1'b1, IDX_TEST_CONTROL_A + 8'(k), 8'h5a ^ 8'(k), junk);
    u_host.acc(1'b1, 1'b0, IDX_TEST_CONTROL_A, 8'hff, junk);
    for (int k = 0; k < 3; k++)
      rdchk(1'b1, IDX_TEST_CONTROL_A + 8'(k), 8'h5a ^ 8'(k));
    rdchk(1'b0, IDX_TEST_CONTROL_A, 8'h00);
    u_host.acc(1'b1, 1'b1, IDX_PORT_BASE_LOW, 8'h61, junk);
    rdchk(1'b1, IDX_PORT_BASE_LOW, 8'h60);
    chk("base", 11'h02e, port_base);
    probe(16'h0060, 1'b0);
    u_host.acc(1'b1, 1'b1, IDX_PORT_BASE_HIGH, 8'hff, junk);
    rdchk(1'b1, IDX_PORT_BASE_HIGH, 8'h07);
    chk("base", 11'h760, port_base);
    probe(16'h0760, 1'b1);
    probe(16'h002e, 1'b0);
    probe(16'hf760, 1'b0);
    @(negedge clk_sys) hard_reset = 1'b1;
    @(negedge clk_sys) hard_reset = 1'b0;
    chk("base", 11'h02e, port_base);
    rdchk(1'b1, IDX_TEST_CONTROL_A, 8'h5a);
    base_address_strap_pin = 1'b1;
    rst_n = 1'b0;
    @(negedge clk_sys) rst_n = 1'b1;
    @(negedge clk_sys);
    chk("base", 11'h04e, port_base);
    rdchk(1'b1, IDX_PORT_BASE_LOW, 8'h4e);
    rdchk(1'b1, IDX_TEST_CONTROL_A, 8'h00);
    give_verdict();
  end
  // Hang guard, well beyond the sequence length
  initial begin
    #50us;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
